// ### hw/apn_pkg.sv
// Package with register map, field layout and shared types of the partner status block
package apn_pkg;

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_PARTNER_ABILITY   = 8'h05;
   localparam logic [7:0] IDX_AUTONEG_EXPANSION = 8'h06;
   localparam logic [7:0] IDX_IRQ_STATUS        = 8'h08;
   localparam logic [7:0] IDX_IRQ_CLEAR         = 8'h09;
   localparam logic [7:0] IDX_IRQ_ENABLE        = 8'h0A;

   // Expansion register bit positions
   localparam int EXP_PARTNER_AUTONEG_POS = 0;
   localparam int EXP_PAGE_RECEIVED_POS   = 1;
   localparam int EXP_LOCAL_NP_POS        = 2;
   localparam int EXP_PARTNER_NP_POS      = 3;
   localparam int EXP_PD_FAULT_POS        = 4;

   // Interrupt status bit positions
   localparam int IRQ_PAGE_POS      = 0;
   localparam int IRQ_FAULT_POS     = 1;
   localparam int IRQ_AUTONEG_POS   = 2;
   localparam int IRQ_W             = 3;

   // Reset values
   localparam logic [15:0]    ABILITY_RESET   = 16'h0000;
   localparam logic [15:0]    EXPANSION_RESET = 16'h0000;
   localparam logic [IRQ_W-1:0] IRQ_RESET     = 3'h0;
   localparam logic           LOCAL_LOCAL_NEXT_PAGE_CAPABLE   = 1'b0;

   // Ability word as received in a link code word
   typedef struct packed {
      logic       partner_next_page;
      logic       partner_ack;
      logic       partner_remote_fault;
      logic [1:0] reserved;
      logic       partner_pause_capable;
      logic       partner_hundred_four_pair;
      logic       partner_hundred_full;
      logic       partner_hundred_half;
      logic       partner_ten_full;
      logic       partner_ten_half;
      logic [4:0] selector;
   } apn_ability_type;

   // Received page handed over by the arbitration engine
   typedef struct packed {
      logic            valid;
      apn_ability_type word;
   } apn_page_type;

   // Bus cycle state
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } apn_bus_state_type;

endpackage

// ### hw/apn_page_capture.sv
// Capture of the link partner ability word from received pages
`timescale 1ns/100ps
`default_nettype none
module apn_page_capture (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire apn_pkg::apn_page_type    page_in,
   input  wire logic                     restart,
   output var  apn_pkg::apn_ability_type ability_reg,
   output logic                          page_pulse_reg
);

   // Captured word; reserved bits are forced low so they always read zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ability_reg <= apn_pkg::ABILITY_RESET;
      end else if (restart) begin
         ability_reg <= apn_pkg::ABILITY_RESET;
      end else if (page_in.valid) begin
         ability_reg          <= page_in.word; // R01 R02 R03 R04 R06 R07 R08
         ability_reg.reserved <= 2'h0;         // R05
      end
   end

   // One pulse per received page, used for the page flag and the interrupt
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         page_pulse_reg <= 1'b0;
      end else begin
         page_pulse_reg <= page_in.valid & ~restart; // R12
      end
   end

endmodule // apn_page_capture
`default_nettype wire

// ### hw/apn_status_regs.sv
// Partner ability and expansion status registers with a Wishbone slave and interrupt
//
// Overview of operation
// R01 - The ability word received from the partner is captured and readable but not writable.
// R02 - Ability bit 15 shows whether the partner offers a next page and resets to 0.
// R03 - Ability bit 14 is the acknowledge from received bursts and ignores software writes.
// R04 - Ability bit 13 shows the partner's remote fault indication.
// R05 - Reserved bits 12-11 of the ability word and 15-5 of the expansion word read zero.
// R06 - Ability bit 10 shows whether the partner advertised pause capability.
// R07 - Ability bits 9 to 5 show T4, 100 full, 100 half, 10 full and 10 half.
// R08 - Ability bits 4-0 hold the partner's selector field and reset to zero.
// R09 - Expansion bit 4 latches a parallel detection fault until read and resets to 0.
// R10 - Expansion bit 3 shows whether the partner is next page able.
// R11 - Expansion bit 2 is always 0 as local next page exchange is not supported.
// R12 - Expansion bit 1 is set when a new page arrives from the partner.
// R13 - Reading the expansion register clears the new page flag.
// R14 - Expansion bit 0 shows whether the partner supports auto-negotiation.
// R15 - Reading the expansion register clears the fault flag unless the fault persists.
`timescale 1ns/100ps
`default_nettype none
module apn_status_regs #(
   parameter int DATA_W = 32,
   parameter int ADDR_W = 8
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   // Wishbone classic slave
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [ADDR_W-1:0]     wb_adr_i,
   input  wire logic [DATA_W/8-1:0]   wb_sel_i,
   input  wire logic [DATA_W-1:0]     wb_dat_i,
   output logic      [DATA_W-1:0]     wb_dat_o,
   output logic                       wb_ack_o,
   // From the auto-negotiation engine
   input  wire apn_pkg::apn_page_type rx_page,
   input  wire logic                  autoneg_restart,
   input  wire logic                  pd_fault_detect,
   input  wire logic                  partner_autoneg_detect,
   // Interrupt
   output logic                       irq
);

   // Refused at elaboration: the read path and lane decode assume one 32-bit word
   if (DATA_W != 32) begin : g_bad_data_w
      $error("apn_status_regs: DATA_W must be 32");
   end
   if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr_w
      $error("apn_status_regs: ADDR_W must be 6 to 32");
   end

   apn_pkg::apn_bus_state_type bus_state_reg;
   apn_pkg::apn_ability_type   ability;
   logic                       page_pulse;
   logic                       pd_fault_reg;
   logic                       page_received_reg;
   logic                       partner_autoneg_reg;
   logic [apn_pkg::IRQ_W-1:0]  irq_status_reg;
   logic [apn_pkg::IRQ_W-1:0]  irq_enable_reg;
   logic                       req;
   logic                       rd_fire;
   logic                       wr_fire;
   logic [7:0]                 idx;
   logic                       idx_valid;
   logic [15:0]                expansion;
   logic [DATA_W-1:0]          rd_data;
   logic [apn_pkg::IRQ_W-1:0]  irq_events;
   logic [apn_pkg::IRQ_W-1:0]  irq_clear;
   logic                       fault_rise;
   logic                       pd_fault_prev_reg;
   logic                       autoneg_rise;

   // Word index from a byte address; low two bits must be zero for a hit
   function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
      word_index = 8'(a >> 2);
   endfunction

   function automatic logic aligned_in_range(input logic [ADDR_W-1:0] a);
      aligned_in_range = (a[1:0] == 2'h0) && ((a >> 2) < (1 << 8));
   endfunction

   // Byte lane write of a narrow field, used for the interrupt clear register
   function automatic logic [apn_pkg::IRQ_W-1:0] lane0(
      input logic [DATA_W/8-1:0] sel,
      input logic [DATA_W-1:0]   data
   );
      lane0 = sel[0] ? data[apn_pkg::IRQ_W-1:0] : {apn_pkg::IRQ_W{1'b0}};
   endfunction

   assign req       = wb_cyc_i & wb_stb_i & (bus_state_reg == apn_pkg::BUS_IDLE);
   assign rd_fire   = req & ~wb_we_i;
   assign wr_fire   = req & wb_we_i;
   assign idx       = word_index(wb_adr_i);
   assign idx_valid = aligned_in_range(wb_adr_i);

   apn_page_capture u_capture (
      .clk            (clk),
      .rst_n          (rst_n),
      .page_in        (rx_page),
      .restart        (autoneg_restart),
      .ability_reg    (ability),
      .page_pulse_reg (page_pulse)
   );

   // Bus cycle: answer one cycle after the request, drop ack the cycle after
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_state_reg <= apn_pkg::BUS_IDLE;
      end else begin
         case (bus_state_reg)
            apn_pkg::BUS_IDLE: begin
               if (req) begin
                  bus_state_reg <= apn_pkg::BUS_ACK;
               end
            end
            apn_pkg::BUS_ACK: begin
               bus_state_reg <= apn_pkg::BUS_IDLE;
            end
            default: begin
               bus_state_reg <= apn_pkg::BUS_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   // Expansion word assembled from live and latched state
   always_comb begin
      expansion                                   = apn_pkg::EXPANSION_RESET; // R05
      expansion[apn_pkg::EXP_PARTNER_AUTONEG_POS] = partner_autoneg_reg;      // R14
      expansion[apn_pkg::EXP_PAGE_RECEIVED_POS]   = page_received_reg;        // R12
      expansion[apn_pkg::EXP_LOCAL_NP_POS]        = apn_pkg::LOCAL_LOCAL_NEXT_PAGE_CAPABLE;   // R11
      expansion[apn_pkg::EXP_PARTNER_NP_POS]      = ability.partner_next_page; // R10
      expansion[apn_pkg::EXP_PD_FAULT_POS]        = pd_fault_reg;             // R09
   end

   // Read multiplexer; unmapped addresses answer with zero
   always_comb begin
      rd_data = '0;
      if (idx_valid) begin
         case (idx)
            apn_pkg::IDX_PARTNER_ABILITY: begin
               rd_data[15:0] = ability; // R01
            end
            apn_pkg::IDX_AUTONEG_EXPANSION: begin
               rd_data[15:0] = expansion;
            end
            apn_pkg::IDX_IRQ_STATUS: begin
               rd_data[apn_pkg::IRQ_W-1:0] = irq_status_reg;
            end
            apn_pkg::IDX_IRQ_ENABLE: begin
               rd_data[apn_pkg::IRQ_W-1:0] = irq_enable_reg;
            end
            default: begin
               rd_data = '0;
            end
         endcase
      end
   end

   // Data is sampled together with ack, before any read side effect lands
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_dat_o <= '0;
      end else if (rd_fire) begin
         wb_dat_o <= rd_data;
      end else if (req) begin
         wb_dat_o <= '0;
      end
   end

   logic exp_read;
   assign exp_read = rd_fire & idx_valid & (idx == apn_pkg::IDX_AUTONEG_EXPANSION);

   // New page flag; a page in the read cycle wins so it is not lost
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         page_received_reg <= 1'b0;
      end else if (page_pulse) begin
         page_received_reg <= 1'b1; // R12
      end else if (exp_read || autoneg_restart) begin
         page_received_reg <= 1'b0; // R13
      end
   end

   // Latched fault; a read only clears it once the condition has gone
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pd_fault_reg <= 1'b0;
      end else if (pd_fault_detect) begin
         pd_fault_reg <= 1'b1; // R09
      end else if (exp_read) begin
         pd_fault_reg <= 1'b0; // R15
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         partner_autoneg_reg <= 1'b0;
      end else if (autoneg_restart) begin
         partner_autoneg_reg <= 1'b0;
      end else begin
         partner_autoneg_reg <= partner_autoneg_detect; // R14
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pd_fault_prev_reg <= 1'b0;
      end else begin
         pd_fault_prev_reg <= pd_fault_detect;
      end
   end

   // Events: new page, fault onset, partner found to auto-negotiate
   assign fault_rise   = pd_fault_detect & ~pd_fault_prev_reg;
   assign autoneg_rise = partner_autoneg_detect & ~partner_autoneg_reg & ~autoneg_restart;

   always_comb begin
      irq_events                        = '0;
      irq_events[apn_pkg::IRQ_PAGE_POS]    = page_pulse;
      irq_events[apn_pkg::IRQ_FAULT_POS]   = fault_rise;
      irq_events[apn_pkg::IRQ_AUTONEG_POS] = autoneg_rise;
   end

   assign irq_clear = (wr_fire && idx_valid && idx == apn_pkg::IDX_IRQ_CLEAR) ?
                      lane0(wb_sel_i, wb_dat_i) : '0;

   // Sticky status; a new event beats a clear in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_status_reg <= apn_pkg::IRQ_RESET;
      end else begin
         irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_events;
      end
   end

   // Writes to the two status registers are acknowledged and dropped
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_enable_reg <= apn_pkg::IRQ_RESET;
      end else if (wr_fire && idx_valid && idx == apn_pkg::IDX_IRQ_ENABLE && wb_sel_i[0]) begin
         irq_enable_reg <= wb_dat_i[apn_pkg::IRQ_W-1:0]; // R03 R05
      end
   end

   // Registered level output taken from the next status value, so irq rises in the same cycle as the status bit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((irq_status_reg & ~irq_clear) | irq_events) & irq_enable_reg);
      end
   end

endmodule // apn_status_regs
`default_nettype wire

// ### testbench/apn_status_regs_chk.sv
// Port-level checks of the partner status register block
`timescale 1ns/100ps
`default_nettype none
module apn_status_regs_chk (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        pd_fault_detect,
   input wire logic        partner_autoneg_detect
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Read answers are judged in their ack cycle, while the master still holds the address
   wire logic rd_exp = wb_ack_o && !wb_we_i && wb_adr_i == 8'h18;
   wire logic rd_abl = wb_ack_o && !wb_we_i && wb_adr_i == 8'h14;
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
   property p_ack_follows;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_follows: assert property (p_ack_follows) else $error("request not answered");
   property p_ack_needs_req;
      !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
   endproperty
   a_ack_needs_req: assert property (p_ack_needs_req) else $error("ack without request");
   property p_abl_rsvd;
      rd_abl |-> wb_dat_o[31:16] == 16'h0000 && wb_dat_o[12:11] == 2'h0;
   endproperty
   a_abl_rsvd: assert property (p_abl_rsvd) else $error("ability reserved bits set");
   property p_exp_rsvd;
      rd_exp |-> wb_dat_o[31:5] == 27'h0000000;
   endproperty
   a_exp_rsvd: assert property (p_exp_rsvd) else $error("expansion reserved bits set");
   property p_local_np;
      rd_exp |-> !wb_dat_o[2];
   endproperty
   a_local_np: assert property (p_local_np) else $error("local next page bit set");
   property p_autoneg;
      rd_exp && $past(partner_autoneg_detect, 2) == $past(partner_autoneg_detect, 3)
         |-> wb_dat_o[0] == $past(partner_autoneg_detect, 2);
   endproperty
   a_autoneg: assert property (p_autoneg) else $error("partner autoneg bit wrong");
   property p_fault;
      rd_exp && $past(pd_fault_detect, 2) && $past(pd_fault_detect, 3) |-> wb_dat_o[4];
   endproperty
   a_fault: assert property (p_fault) else $error("fault bit not shown");
endmodule // apn_status_regs_chk
bind apn_status_regs apn_status_regs_chk i_apn_status_regs_chk (
   .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .pd_fault_detect(pd_fault_detect), .partner_autoneg_detect(partner_autoneg_detect));
`default_nettype wire

// ### testbench/apn_link_partner.sv
// Behavioural model of the remote link partner and its page delivery
`timescale 1ns/100ps
`default_nettype none
module apn_link_partner (
   input  wire logic             clk,
   output var apn_pkg::apn_page_type rx_page,
   output logic                  pd_fault_detect,
   output logic                  partner_autoneg_detect
);
   initial begin
      rx_page = '0;
      pd_fault_detect = 1'b0;
      partner_autoneg_detect = 1'b0;
   end
   // Word turns to its inverse once valid drops, so a stale word is never mistaken for data
   task automatic send_page(input logic [15:0] w);
      @(posedge clk);
      rx_page <= {1'b1, w};
      @(posedge clk);
      rx_page <= {1'b0, ~w};
   endtask
   task automatic set_fault(input logic v);
      @(posedge clk);
      pd_fault_detect <= v;
   endtask
   task automatic set_autoneg(input logic v);
      @(posedge clk);
      partner_autoneg_detect <= v;
   endtask
endmodule // apn_link_partner
`default_nettype wire

// ### testbench/test_apn_status_regs.sv
// Self-checking bench of the partner status register block
`timescale 1ns/100ps
`default_nettype none
module test_apn_status_regs;
   logic                  clk = 1'b0;
   logic                  rst_n = 1'b0;
   logic                  cyc = 1'b0, stb = 1'b0, we = 1'b0, restart = 1'b0;
   logic [7:0]            adr = 8'h00;
   logic [3:0]            sel = 4'h0;
   logic [3:0]            lanes = 4'hF;
   logic [31:0]           wdat = 32'h0, dat_o, rd;
   logic                  ack, irq, parallel_detect_fault, ane;
   apn_pkg::apn_page_type page;
   logic [15:0]           words [3] = '{16'hFFFF, 16'h1800, 16'h2155};
   int                    n_errors = 0, checked = 0;
   initial begin
      forever #5 clk = ~clk;
   end
   apn_status_regs i_apn_status_regs (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .rx_page(page), .autoneg_restart(restart), .pd_fault_detect(parallel_detect_fault),
      .partner_autoneg_detect(ane), .irq(irq));
   apn_link_partner i_apn_link_partner (.clk(clk), .rx_page(page), .pd_fault_detect(parallel_detect_fault),
      .partner_autoneg_detect(ane));
   task automatic summarize;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= lanes;
      @(posedge clk);
      while (ack !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      if (n == 20) n_errors++;
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   initial begin
      #20000;
      n_errors++;
      summarize();
   end
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rdc(8'h14, 32'h0);
      rdc(8'h18, 32'h0);
      bus(1'b1, 8'h14, 32'hFFFF);
      rdc(8'h14, 32'h0);
      bus(1'b1, 8'h28, 32'h7);
      rdc(8'h28, 32'h7);
      lanes = 4'hE;
      bus(1'b1, 8'h28, 32'h0);
      lanes = 4'hF;
      rdc(8'h28, 32'h7);
      rdc(8'h3C, 32'h0);
      i_apn_link_partner.set_autoneg(1'b1);
      for (int i = 0; i < 3; i++) begin
         i_apn_link_partner.send_page(words[i]);
         repeat (3) @(posedge clk);
         rdc(8'h14, {16'h0, words[i] & 16'hE7FF});
         rdc(8'h18, {28'h0, words[i][15], 3'b011});
         rdc(8'h18, {28'h0, words[i][15], 3'b001});
      end
      chk({31'h0, irq}, 32'h1);
      rdc(8'h20, 32'h5);
      bus(1'b1, 8'h24, 32'h7);
      rdc(8'h20, 32'h0);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, 8'h28, 32'h2);
      i_apn_link_partner.set_fault(1'b1);
      repeat (4) @(posedge clk);
      i_apn_link_partner.set_fault(1'b0);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      rdc(8'h18, 32'h11);
      rdc(8'h18, 32'h01);
      i_apn_link_partner.set_fault(1'b1);
      repeat (3) @(posedge clk);
      rdc(8'h18, 32'h11);
      rdc(8'h18, 32'h11);
      i_apn_link_partner.set_fault(1'b0);
      bus(1'b1, 8'h24, 32'h7);
      bus(1'b1, 8'h28, 32'h0);
      i_apn_link_partner.send_page(16'h0421);
      repeat (3) @(posedge clk);
      rdc(8'h20, 32'h1);
      chk({31'h0, irq}, 32'h0);
      bus(1'b1, 8'h28, 32'h1);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      rdc(8'h14, 32'h0421);
      @(posedge clk);
      restart <= 1'b1;
      @(posedge clk);
      restart <= 1'b0;
      rdc(8'h14, 32'h0);
      i_apn_link_partner.send_page(16'hA001);
      repeat (3) @(posedge clk);
      rdc(8'h14, 32'hA001);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rdc(8'h14, 32'h0);
      rdc(8'h18, 32'h1);
      summarize();
   end
endmodule // test_apn_status_regs
`default_nettype wire
